/* File: core/ook_line_timer.sv */
// carrier divider and bit-period tick generator
`timescale 1ns/100ps
`default_nettype none
module ook_line_timer
  import ook_modem_pkg::*;
(
  input  wire logic       core_clk_i,   // core clock
  input  wire logic       reset_i,      // sync reset, high
  input  wire logic       run_i,        // send carrier
  input  wire logic       restart_i,    // realign bit timing
  input  wire logic [1:0] rate_sel_i,   // data rate select
  output logic            carrier_o,    // carrier, clock / 4
  output logic            bit_tick_o    // one pulse per bit period
);

  logic [1:0]           phase_r;
  logic [1:0]           phase_nxt;
  logic [BIT_CNT_W-1:0] bit_cnt_r;
  logic [BIT_CNT_W-1:0] bit_cnt_nxt;
  logic                 tick_nxt;

  always_comb
  begin
    // carrier is the top bit of a four-state phase count
    phase_nxt   = run_i ? phase_r + 2'h1 : 2'h0;
    tick_nxt    = 1'b0;
    bit_cnt_nxt = bit_cnt_r + 11'h001;
    if (restart_i)
    begin
      bit_cnt_nxt = 11'h000;
    end
    else if (bit_cnt_r >= bit_period(rate_sel_i) - 11'h001)
    begin
      bit_cnt_nxt = 11'h000;
      tick_nxt    = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      phase_r    <= 2'h0;
      bit_cnt_r  <= 11'h000;
      bit_tick_o <= 1'b0;
    end
    else
    begin
      phase_r    <= phase_nxt;
      bit_cnt_r  <= bit_cnt_nxt;
      bit_tick_o <= tick_nxt;
    end
  end

  assign carrier_o = phase_r[1];

  property p_carrier_half_period;
    @(posedge core_clk_i) disable iff (reset_i)
    run_i [*3] |-> carrier_o != $past(carrier_o, 2);
  endproperty
  a_carrier_half_period: assert property (p_carrier_half_period)
    else $error("carrier half period is not two cycles");

  c_carrier_runs: cover property (
    @(posedge core_clk_i) disable iff (reset_i) run_i [*8]);

endmodule : ook_line_timer
`default_nettype wire

/* File: core/ook_modem_pkg.sv */
// constants and types shared by the modem status and id register block
package ook_modem_pkg;

  // register addresses as carried in the 7-bit serial address field
  localparam logic [6:0] STATUS_ADDR   = 7'h07;
  localparam logic [6:0] PART_ADDR     = 7'h08;
  localparam logic [6:0] REVISION_ADDR = 7'h09;

  // status field positions
  localparam int TX_ACTIVE_BIT = 2;
  localparam int RX_STATE_BIT  = 1;
  localparam int DIR_BIT       = 0;

  // status reset values
  localparam logic TX_ACTIVE_RESET = 1'b1;
  localparam logic RX_STATE_RESET  = 1'b1;
  localparam logic DIR_RESET       = 1'b0;

  // serial frame: bit 15 read flag, 14:8 address, 7:0 data
  localparam int FRAME_BITS   = 16;
  localparam int HEADER_BITS  = 8;
  localparam int READ_FLAG_AT = 7;

  // synchroniser lanes and their idle levels
  localparam int SYNC_W     = 5;
  localparam int LANE_SCLK  = 0;
  localparam int LANE_CS_N  = 1;
  localparam int LANE_MOSI  = 2;
  localparam int LANE_TX_DATA_PIN  = 3;
  localparam int LANE_RX    = 4;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h0A;

  // timing
  localparam int CORE_CLK_HZ    = 10_000_000;
  localparam int CARRIER_DIVIDE = 4;
  localparam int DWELL_BITS     = 16;
  localparam int BAUD_9600      = 9_600;
  localparam int BAUD_38400     = 38_400;
  localparam int BAUD_115200    = 115_200;
  localparam int BIT_CNT_W      = 11;
  localparam logic [BIT_CNT_W-1:0] BIT_CYCLES_9600 =
    BIT_CNT_W'(CORE_CLK_HZ / BAUD_9600);
  localparam logic [BIT_CNT_W-1:0] BIT_CYCLES_38400 =
    BIT_CNT_W'(CORE_CLK_HZ / BAUD_38400);
  localparam logic [BIT_CNT_W-1:0] BIT_CYCLES_115200 =
    BIT_CNT_W'(CORE_CLK_HZ / BAUD_115200);

  typedef struct packed {
    logic tx_carrier_active;
    logic rx_carrier_state;
    logic dir;
  } line_status_t;

  typedef enum logic [1:0] {
    LINE_IDLE    = 2'b00,
    LINE_RECEIVE = 2'b01,
    LINE_DWELL   = 2'b11
  } line_state_t;

  function automatic logic [BIT_CNT_W-1:0] bit_period(
    input logic [1:0] sel
  );
    logic [BIT_CNT_W-1:0] cycles;
    cycles = BIT_CYCLES_9600;
    if (sel == 2'h1)
    begin
      cycles = BIT_CYCLES_38400;
    end
    else if (sel == 2'h2)
    begin
      cycles = BIT_CYCLES_115200;
    end
    return cycles;
  endfunction : bit_period

endpackage : ook_modem_pkg

/* File: core/ook_modem_status_id_regs.sv */
// modem line status and identification registers behind the serial port
`timescale 1ns/100ps
`default_nettype none
// Contract
// - with direction low, status bit 2 is 1 while the transmit pin is low or software transmit enable is set and carrier goes out, 0 otherwise.
// - with direction high, status bit 1 is 0 while carrier is received and 1 while it is absent.
// - status bit 0 goes to 1 once carrier is seen on the selected port and stays 0 while none is seen.
// - a fixed read-only 8-bit part code is returned and writes do not change it.
// - a fixed read-only 8-bit silicon revision code is returned and writes do not change it.
// - carrier timing comes from the reference clock divided by four.
// - carrier is sent and reported active when direction is low and the transmit pin is low or software transmit enable is set.
// - after received carrier ends, direction stays in receive for sixteen bit periods before going idle.
module ook_modem_status_id_regs
  import ook_modem_pkg::*;
#(
  parameter logic [7:0] PART_CODE             = 8'h5A, // arbitrary value
  parameter logic [7:0] SILICON_REVISION_CODE = 8'h01  // arbitrary value
)
(
  input  wire logic       core_clk_i,             // reference clock
  input  wire logic       reset_i,                // sync reset, high
  input  wire logic       spi_sclk_i,             // serial clock pin
  input  wire logic       spi_cs_n_i,             // serial select, low
  input  wire logic       spi_mosi_i,             // serial data in
  output logic            spi_miso_o,             // serial data out
  output logic            spi_miso_oe_o,          // drive data out
  input  wire logic       tx_data_pin_n_i,        // transmit data, low
  input  wire logic       rf_receive_input_i,     // carrier detected
  input  wire logic       tx_on_i,                // software tx enable
  input  wire logic [1:0] data_rate_sel_i,        // data rate select
  output logic            tx_carrier_active_o,    // carrier going out
  output logic            rx_carrier_state_o,     // receive out, low=on
  output logic            dir_o,                  // direction, high=rx
  output logic            carrier_o               // modulated carrier
);

  logic [SYNC_W-1:0] s1_r;
  logic [SYNC_W-1:0] s2_r;
  logic [SYNC_W-1:0] s3_r;
  logic [SYNC_W-1:0] filt_r;
  logic [SYNC_W-1:0] filt_nxt;

  // a lane changes only when stages two and three agree
  always_comb
  begin
    filt_nxt = (s2_r & ~(s2_r ^ s3_r)) | (filt_r & (s2_r ^ s3_r));
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      s1_r   <= SYNC_RESET;
      s2_r   <= SYNC_RESET;
      s3_r   <= SYNC_RESET;
      filt_r <= SYNC_RESET;
    end
    else
    begin
      s1_r   <= {rf_receive_input_i, tx_data_pin_n_i, spi_mosi_i,
                 spi_cs_n_i, spi_sclk_i};
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  logic rx_seen;
  logic tx_request;
  assign rx_seen    = filt_r[LANE_RX];
  assign tx_request = ~filt_r[LANE_TX_DATA_PIN] | tx_on_i;

  // line direction and dwell
  line_state_t  state_r;
  line_state_t  state_nxt;
  logic [4:0]   dwell_cnt_r;
  logic [4:0]   dwell_cnt_nxt;
  line_status_t status_r;
  line_status_t status_nxt;
  logic         bit_tick;
  logic         dwell_start;

  assign dwell_start = (state_r == LINE_RECEIVE) && !rx_seen;

  always_comb
  begin
    state_nxt     = state_r;
    dwell_cnt_nxt = dwell_cnt_r;
    unique case (state_r)
      LINE_IDLE:
      begin
        if (rx_seen)
        begin
          state_nxt = LINE_RECEIVE;
        end
      end
      LINE_RECEIVE:
      begin
        dwell_cnt_nxt = 5'h00;
        if (!rx_seen)
        begin
          state_nxt = LINE_DWELL;
        end
      end
      LINE_DWELL:
      begin
        if (rx_seen)
        begin
          state_nxt = LINE_RECEIVE;
        end
        else if (bit_tick)
        begin
          // idle only after the full dwell of bit periods
          if (dwell_cnt_r == 5'(DWELL_BITS - 1))
          begin
            state_nxt = LINE_IDLE;
          end
          dwell_cnt_nxt = dwell_cnt_r + 5'h01;
        end
      end
      default:
      begin
        state_nxt = LINE_IDLE;
      end
    endcase
    status_nxt.dir = (state_nxt != LINE_IDLE);
    // own carrier is not sent while the line is receiving
    status_nxt.tx_carrier_active =
      tx_request && !status_r.dir;
    status_nxt.rx_carrier_state =
      status_r.dir ? !rx_seen : RX_STATE_RESET;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state_r     <= LINE_IDLE;
      dwell_cnt_r <= 5'h00;
      status_r    <= '{TX_ACTIVE_RESET, RX_STATE_RESET, DIR_RESET};
    end
    else
    begin
      state_r     <= state_nxt;
      dwell_cnt_r <= dwell_cnt_nxt;
      status_r    <= status_nxt;
    end
  end

  ook_line_timer u_timer (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .run_i      (status_r.tx_carrier_active),
    .restart_i  (dwell_start),
    .rate_sel_i (data_rate_sel_i),
    .carrier_o  (carrier_o),
    .bit_tick_o (bit_tick)
  );

  assign tx_carrier_active_o = status_r.tx_carrier_active;
  assign rx_carrier_state_o  = status_r.rx_carrier_state;
  assign dir_o               = status_r.dir;

  // serial slave, mode 0, msb first
  logic [FRAME_BITS-1:0] rx_shift_r;
  logic [FRAME_BITS-1:0] rx_shift_nxt;
  logic [4:0]            cnt_r;
  logic [4:0]            cnt_nxt;
  logic [7:0]            tx_shift_r;
  logic [7:0]            tx_shift_nxt;
  logic                  sclk_prev_r;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  selected;
  logic                  load;
  logic [7:0]            read_data;

  assign selected  = !filt_r[LANE_CS_N];
  assign sclk_rise = filt_r[LANE_SCLK] && !sclk_prev_r;
  assign sclk_fall = !filt_r[LANE_SCLK] && sclk_prev_r;
  assign load      = selected && sclk_fall && (cnt_r == 5'(HEADER_BITS))
                     && rx_shift_r[READ_FLAG_AT];

  always_comb
  begin
    // writes land nowhere: every register here is read-only
    read_data = 8'h00;
    unique case (rx_shift_r[6:0])
      STATUS_ADDR:   read_data = {5'h00, status_r};
      PART_ADDR:     read_data = PART_CODE;
      REVISION_ADDR: read_data = SILICON_REVISION_CODE;
      default:       read_data = 8'h00;
    endcase
    rx_shift_nxt = rx_shift_r;
    cnt_nxt      = cnt_r;
    tx_shift_nxt = tx_shift_r;
    if (!selected)
    begin
      cnt_nxt      = 5'h00;
      tx_shift_nxt = 8'h00;
    end
    else
    begin
      if (sclk_rise && cnt_r < 5'(FRAME_BITS))
      begin
        rx_shift_nxt = {rx_shift_r[FRAME_BITS-2:0], filt_r[LANE_MOSI]};
        cnt_nxt      = cnt_r + 5'h01;
      end
      if (load)
      begin
        tx_shift_nxt = read_data;
      end
      else if (sclk_fall && cnt_r > 5'(HEADER_BITS))
      begin
        tx_shift_nxt = {tx_shift_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      rx_shift_r  <= 16'h0000;
      cnt_r       <= 5'h00;
      tx_shift_r  <= 8'h00;
      sclk_prev_r <= 1'b0;
    end
    else
    begin
      rx_shift_r  <= rx_shift_nxt;
      cnt_r       <= cnt_nxt;
      tx_shift_r  <= tx_shift_nxt;
      sclk_prev_r <= filt_r[LANE_SCLK];
    end
  end

  assign spi_miso_o    = tx_shift_r[7];
  assign spi_miso_oe_o = selected;

  property p_tx_bit;
    @(posedge core_clk_i) disable iff (reset_i)
    !status_r.dir && !$past(status_r.dir) |=>
      tx_carrier_active_o == $past(tx_request);
  endproperty
  a_tx_bit: assert property (p_tx_bit)
    else $error("transmit activity bit does not follow request");

  property p_rx_bit;
    @(posedge core_clk_i) disable iff (reset_i)
    status_r.dir |=> rx_carrier_state_o == !$past(rx_seen);
  endproperty
  a_rx_bit: assert property (p_rx_bit)
    else $error("receive bit is not the inverse of carrier");

  property p_dir_set;
    @(posedge core_clk_i) disable iff (reset_i)
    rx_seen |=> dir_o;
  endproperty
  a_dir_set: assert property (p_dir_set)
    else $error("direction not raised on carrier");

  property p_part_read;
    @(posedge core_clk_i) disable iff (reset_i)
    load && rx_shift_r[6:0] == PART_ADDR |=> tx_shift_r == PART_CODE;
  endproperty
  a_part_read: assert property (p_part_read)
    else $error("part code read wrong");

  property p_rev_read;
    @(posedge core_clk_i) disable iff (reset_i)
    load && rx_shift_r[6:0] == REVISION_ADDR |=>
      tx_shift_r == SILICON_REVISION_CODE;
  endproperty
  a_rev_read: assert property (p_rev_read)
    else $error("revision code read wrong");

  property p_no_carrier_when_off;
    @(posedge core_clk_i) disable iff (reset_i)
    !tx_carrier_active_o |=> !carrier_o;
  endproperty
  a_no_carrier_when_off: assert property (p_no_carrier_when_off)
    else $error("carrier present while transmit inactive");

  property p_dwell_holds;
    @(posedge core_clk_i) disable iff (reset_i)
    state_r == LINE_DWELL && dwell_cnt_r < 5'h0F |=> dir_o;
  endproperty
  a_dwell_holds: assert property (p_dwell_holds)
    else $error("direction dropped before dwell ended");

  property p_dir_fall_after_dwell;
    @(posedge core_clk_i) disable iff (reset_i)
    $fell(dir_o) |-> $past(dwell_cnt_r) == 5'h0F && $past(bit_tick);
  endproperty
  a_dir_fall_after_dwell: assert property (p_dir_fall_after_dwell)
    else $error("direction fell without full dwell");

  property p_status_upper_zero;
    @(posedge core_clk_i) disable iff (reset_i)
    load && rx_shift_r[6:0] == STATUS_ADDR |=> tx_shift_r[7:3] == 5'h00
      && tx_shift_r[2:0] == $past(status_r);
  endproperty
  a_status_upper_zero: assert property (p_status_upper_zero)
    else $error("status read not live or upper bits set");

  c_receive_dwell_idle: cover property (
    @(posedge core_clk_i) disable iff (reset_i) $fell(dir_o));
  c_status_read: cover property (
    @(posedge core_clk_i) disable iff (reset_i)
    load && rx_shift_r[6:0] == STATUS_ADDR);
  c_transmit: cover property (
    @(posedge core_clk_i) disable iff (reset_i) $rose(tx_carrier_active_o));

endmodule : ook_modem_status_id_regs
`default_nettype wire

/* File: dv/ook_modem_status_id_regs_bench.sv */
// self-checking bench for the modem status and id registers
`timescale 1ns/100ps
`default_nettype none
module ook_modem_status_id_regs_bench
  import ook_modem_pkg::*;
;
  localparam logic [7:0] PART_VAL = 8'h3C; // arbitrary value
  localparam logic [7:0] REV_VAL  = 8'h61; // arbitrary value

  logic       core_clk = 1'b0;
  logic       reset;
  logic       sclk;
  logic       cs_n;
  logic       mosi;
  logic       miso;
  logic       miso_oe;
  logic       txd_n;
  logic       rx_in;
  logic       tx_on;
  logic [1:0] rate_sel;
  logic       tx_act;
  logic       rx_state;
  logic       dir;
  logic       carrier;
  int         err_count;
  int         checks;
  int         oe_cycles;

  always #50 core_clk = ~core_clk;

  // data out must be driven only while a frame is selected
  always @(negedge core_clk)
  begin
    if (miso_oe === 1'b1)
      oe_cycles++;
  end

  ook_modem_status_id_regs #(
    .PART_CODE             (PART_VAL),
    .SILICON_REVISION_CODE (REV_VAL)
  ) u_dut (
    .core_clk_i          (core_clk),
    .reset_i             (reset),
    .spi_sclk_i          (sclk),
    .spi_cs_n_i          (cs_n),
    .spi_mosi_i          (mosi),
    .spi_miso_o          (miso),
    .spi_miso_oe_o       (miso_oe),
    .tx_data_pin_n_i     (txd_n),
    .rf_receive_input_i  (rx_in),
    .tx_on_i             (tx_on),
    .data_rate_sel_i     (rate_sel),
    .tx_carrier_active_o (tx_act),
    .rx_carrier_state_o  (rx_state),
    .dir_o               (dir),
    .carrier_o           (carrier)
  );

  ook_spi_host_model u_host (
    .core_clk_i (core_clk),
    .spi_miso_i (miso),
    .spi_sclk_o (sclk),
    .spi_cs_n_o (cs_n),
    .spi_mosi_o (mosi)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic rd_reg(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    u_host.xfer(1'b1, addr, 8'h00, d);
    chk(d, exp);
  endtask : rd_reg

  task automatic wr_reg(input logic [6:0] addr, input logic [7:0] wd);
    logic [7:0] d;
    u_host.xfer(1'b0, addr, wd, d);
  endtask : wr_reg

  task automatic summarize();
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize

  // longest path is four receive dwells, well under this span
  initial
  begin
    repeat (80000) @(posedge core_clk);
    err_count++;
    summarize();
  end

  initial
  begin
    int   n;
    int   per;
    logic prev;
    reset = 1'b1;
    txd_n = 1'b1;
    rx_in = 1'b0;
    tx_on = 1'b0;
    rate_sel = 2'h2;
    err_count = 0;
    checks = 0;
    oe_cycles = 0;
    repeat (2) @(negedge core_clk);
    chk({5'h00, tx_act, rx_state, dir}, 8'h06);
    chk({6'h00, miso_oe, carrier}, 8'h00);
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    repeat (8) @(negedge core_clk);
    rd_reg(PART_ADDR, PART_VAL);
    rd_reg(REVISION_ADDR, REV_VAL);
    chk(8'(oe_cycles > 512), 8'h01);
    chk({7'h00, miso_oe}, 8'h00);
    wr_reg(PART_ADDR, ~PART_VAL);
    wr_reg(REVISION_ADDR, ~REV_VAL);
    wr_reg(STATUS_ADDR, 8'hFF);
    rd_reg(PART_ADDR, PART_VAL);
    rd_reg(REVISION_ADDR, REV_VAL);
    rd_reg(STATUS_ADDR, 8'h02);
    rd_reg(7'h0A, 8'h00);
    txd_n = 1'b0;
    repeat (8) @(negedge core_clk);
    chk({7'h00, tx_act}, 8'h01);
    n = 0;
    repeat (16)
    begin
      prev = carrier;
      @(negedge core_clk);
      if (carrier !== prev)
        n++;
    end
    chk(8'(n), 8'h08);
    rd_reg(STATUS_ADDR, 8'h06);
    txd_n = 1'b1;
    repeat (8) @(negedge core_clk);
    chk({6'h00, tx_act, carrier}, 8'h00);
    rd_reg(STATUS_ADDR, 8'h02);
    tx_on = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({7'h00, tx_act}, 8'h01);
    rd_reg(STATUS_ADDR, 8'h06);
    tx_on = 1'b0;
    repeat (4) @(negedge core_clk);
    for (int s = 0; s < 4; s++)
    begin
      rate_sel = 2'(s);
      per = (s == 1) ? CORE_CLK_HZ / BAUD_38400 :
            (s == 2) ? CORE_CLK_HZ / BAUD_115200 : CORE_CLK_HZ / BAUD_9600;
      rx_in = 1'b1;
      repeat (10) @(negedge core_clk);
      chk({6'h00, rx_state, dir}, 8'h01);
      rd_reg(STATUS_ADDR, 8'h01);
      rx_in = 1'b0;
      repeat (10) @(negedge core_clk);
      chk({6'h00, rx_state, dir}, 8'h03);
      n = 10;
      while (dir === 1'b1 && n < 16 * (per + 2) + 100)
      begin
        @(negedge core_clk);
        n++;
      end
      chk(8'(n >= 16 * per), 8'h01);
      chk(8'(n <= 16 * (per + 1) + 12), 8'h01);
      repeat (4) @(negedge core_clk);
      chk({6'h00, rx_state, dir}, 8'h02);
    end
    summarize();
  end
endmodule : ook_modem_status_id_regs_bench
`default_nettype wire

/* File: dv/ook_spi_host_model.sv */
// serial host model that polls the modem registers
`timescale 1ns/100ps
`default_nettype none
module ook_spi_host_model
(
  input  wire logic core_clk_i,  // core clock
  input  wire logic spi_miso_i,  // serial data from modem
  output logic      spi_sclk_o,  // serial clock, idles low
  output logic      spi_cs_n_o,  // select, low
  output logic      spi_mosi_o   // serial data to modem
);
  // half period well above the 2-cycle floor of the pin filter
  localparam int HALF = 8;

  initial
  begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_mosi_o = 1'b0;
  end

  // one 16-bit mode 0 frame; rdat keeps the last eight bits shifted back
  task automatic xfer(input logic rd, input logic [6:0] addr,
                      input logic [7:0] wd, output logic [7:0] rdat);
    logic [15:0] frame;
    frame = {rd, addr, wd};
    rdat = 8'h00;
    @(negedge core_clk_i);
    spi_cs_n_o = 1'b0;
    repeat (HALF) @(negedge core_clk_i);
    for (int i = 15; i >= 0; i--)
    begin
      spi_mosi_o = frame[i];
      repeat (HALF) @(negedge core_clk_i);
      spi_sclk_o = 1'b1;
      rdat = {rdat[6:0], spi_miso_i};
      repeat (HALF) @(negedge core_clk_i);
      spi_sclk_o = 1'b0;
    end
    repeat (HALF) @(negedge core_clk_i);
    spi_cs_n_o = 1'b1;
    // released data line must not keep looking valid
    spi_mosi_o = ~spi_mosi_o;
    repeat (HALF) @(negedge core_clk_i);
  endtask : xfer
endmodule : ook_spi_host_model
`default_nettype wire
